//--- design/thc_monitor.sv
// Behaviour
// - Permit only if second hand actuates within 500 ms of the first.
// - Window expiry holds permit off until both hands are released.
// - Permit stays on only while both hands stay actuated.
// - Permit drops as soon as either hand is seen released.
// - After a drop, both hands must release and re-actuate before permit.
`timescale 1ns/1ps
`include "thc_consts.svh"
module dhi_monitor
    import dhi_pkg::*;
#(
    parameter int unsigned TICK_CYC = `DHI_TICK_CYC // Clock cycles per window tick.
)
(
    input wire logic CLOCK_I, // 200 MHz system clock.
    input wire logic RST_N_I, // Synchronous reset, active low.
    input wire logic HAND_A_I, // Hand control A, high when actuated.
    input wire logic HAND_B_I, // Hand control B, high when actuated.
    output logic RUN_PERMIT_O, // Run permit, high allows hazardous motion.
    output logic WAIT_RELEASE_O // High while both hands must be released.
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Both pins come from switches outside the clock domain, so each
    // passes its own filtered synchroniser before the sequencer sees it.
    logic [1:0] pin_raw;
    logic [1:0] hand_lvl;
    logic hand_a;
    logic hand_b;

    assign pin_raw = {HAND_B_I, HAND_A_I};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            dhi_sync u_dhi_sync
            (
                .clk_i(CLOCK_I),
                .rst_n_i(RST_N_I),
                .pin_i(pin_raw[gi]),
                .lvl_o(hand_lvl[gi])
            );
        end
    endgenerate

    assign hand_a = hand_lvl[0];
    assign hand_b = hand_lvl[1];

    // ----------------------------------------------------------------
    // Shared decoding
    // ----------------------------------------------------------------
    function automatic logic in_state(input dhi_state_e cur, input dhi_state_e want);
        return (cur == want);
    endfunction

    // ----------------------------------------------------------------
    // State and hand decoding
    // ----------------------------------------------------------------
    dhi_state_e state_q;
    dhi_state_e state_d;

    wire both_on = hand_a & hand_b;
    wire both_off = ~hand_a & ~hand_b;
    wire any_on = hand_a | hand_b;
    wire armed = in_state(state_q, DHI_ARMED);

    // ----------------------------------------------------------------
    // Window tick divider
    // ----------------------------------------------------------------
    // The divider restarts whenever the sequencer is not armed, so the
    // window is measured from the first hand, not from a free tick phase.
    localparam logic [`DHI_TICK_W-1:0] TICK_LAST = `DHI_TICK_W'(TICK_CYC - 1);

    logic [`DHI_TICK_W-1:0] tick_cnt_q;
    logic [`DHI_TICK_W-1:0] tick_cnt_d;

    wire tick = armed && (tick_cnt_q == TICK_LAST);

    assign tick_cnt_d = (!armed || tick) ? '0 : tick_cnt_q + `DHI_TICK_W'(1);

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            tick_cnt_q <= '0;
        else
            tick_cnt_q <= tick_cnt_d;
    end

    // ----------------------------------------------------------------
    // Simultaneity window counter
    // ----------------------------------------------------------------
    localparam logic [`DHI_WIN_W-1:0] WIN_MS = `DHI_WIN_W'(`DHI_WINDOW_MS);

    logic [`DHI_WIN_W-1:0] ms_q;
    logic [`DHI_WIN_W-1:0] ms_d;

    wire expired = (ms_q >= WIN_MS);

    assign ms_d = !armed ? '0 : (tick ? ms_q + `DHI_WIN_W'(1) : ms_q);

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            ms_q <= '0;
        else
            ms_q <= ms_d;
    end

    sequence s_armed_tick;
        armed && tick && !expired;
    endsequence

    a_tick_counts: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        s_armed_tick |=> ms_q == $past(ms_q) + `DHI_WIN_W'(1) || !armed)
        else $error("Window counter missed a tick.");

    a_window_bound: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        ms_q <= WIN_MS)
        else $error("Window counter ran past the window.");

    // ----------------------------------------------------------------
    // Dual hand initiation sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            DHI_WAIT_REL:
            begin
                if (both_off)
                    state_d = DHI_IDLE;
            end
            DHI_IDLE:
            begin
                if (both_on)
                    state_d = DHI_RUN;
                else if (any_on)
                    state_d = DHI_ARMED;
            end
            DHI_ARMED:
            begin
                // Expiry wins over a late second hand in the same cycle.
                if (both_off)
                    state_d = DHI_IDLE;
                else if (expired)
                    state_d = DHI_WAIT_REL;
                else if (both_on)
                    state_d = DHI_RUN;
            end
            DHI_RUN:
            begin
                if (!both_on)
                    state_d = DHI_WAIT_REL;
            end
            default:
                state_d = DHI_WAIT_REL;
        endcase
    end

    // Reset lands in the release wait, so a held hand cannot start a cycle.
    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_N_I)
            state_q <= DHI_WAIT_REL;
        else
            state_q <= state_d;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // The permit is decoded from state; it drops the cycle after a release is seen.
    assign RUN_PERMIT_O = in_state(state_q, DHI_RUN);
    assign WAIT_RELEASE_O = in_state(state_q, DHI_WAIT_REL);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_release_seen;
        RUN_PERMIT_O && !both_on;
    endsequence

    a_drop_on_release: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        s_release_seen |=> !RUN_PERMIT_O)
        else $error("Permit stayed on after a hand release.");

    a_permit_needs_both: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        $rose(RUN_PERMIT_O) |-> $past(both_on))
        else $error("Permit rose without both hands actuated.");

    a_permit_in_window: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (armed && state_d == DHI_RUN) |-> ms_q < WIN_MS)
        else $error("Permit granted outside the simultaneity window.");

    a_expiry_locks: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (armed && expired && !both_off) |=> WAIT_RELEASE_O && !RUN_PERMIT_O)
        else $error("Window expiry did not force release wait.");

    a_wait_no_permit: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        WAIT_RELEASE_O |-> !RUN_PERMIT_O)
        else $error("Permit on during release wait.");

    a_wait_holds: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (WAIT_RELEASE_O && !both_off) |=> WAIT_RELEASE_O)
        else $error("Release wait left while a hand was actuated.");

    a_no_restart: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        $fell(RUN_PERMIT_O) |-> WAIT_RELEASE_O)
        else $error("Permit drop did not demand a release.");

    a_reset_wait: assert property (@(posedge CLOCK_I)
        !$past(RST_N_I) |-> WAIT_RELEASE_O && !RUN_PERMIT_O)
        else $error("Reset did not demand a release.");

    a_permit_from_idle: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        $rose(RUN_PERMIT_O) |-> $past(state_q) != DHI_WAIT_REL)
        else $error("Permit rose straight from release wait.");

    // ----------------------------------------------------------------
    // Limitations
    // ----------------------------------------------------------------
    // The window is resolved to whole ticks of the divider; the default
    // tick of one millisecond keeps that error far below the window.
    // A stuck contact is not diagnosed here: a hand held through a drop
    // simply keeps the block in the release wait, which is the safe side.
    // Anti-repeat control of the machine cycle stays with the machine.
endmodule // dhi_monitor

//--- design/thc_consts.svh
`ifndef DHI_CONSTS_SVH
`define DHI_CONSTS_SVH

// Simultaneity window, counted in ticks of one millisecond.
`define DHI_WINDOW_MS 500
// Clock cycles in one millisecond at 200 MHz.
`define DHI_TICK_CYC 200000
`define DHI_TICK_W 18
// One bit of headroom above the window count.
`define DHI_WIN_W 10

`endif

//--- design/thc_pkg.sv
package dhi_pkg;
    typedef enum logic [1:0] {
        DHI_WAIT_REL,
        DHI_IDLE,
        DHI_ARMED,
        DHI_RUN
    } dhi_state_e;
endpackage

//--- design/thc_sync.sv
`timescale 1ns/1ps
module dhi_sync
(
    input wire logic clk_i, // System clock.
    input wire logic rst_n_i, // Synchronous reset, active low.
    input wire logic pin_i, // Raw input from outside.
    output logic lvl_o // Filtered level.
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    wire agree = (s2_q == s3_q);

    // A change is taken only once the second and third stages agree.
    // Reset loads the actuated level, so the sequencer never sees a false
    // release while the stages still hold nothing sampled from the pin.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            lvl_q <= 1'b1;
        end
        else
        begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree)
                lvl_q <= s3_q;
        end
    end

    assign lvl_o = lvl_q;
endmodule // dhi_sync

//--- verification/thc_hand_ctl.sv
`timescale 1ns/1ps
module dhi_hand_ctl
(
    input wire logic clk_i, // Bench clock.
    input wire logic press_a_i, // Operator holds A.
    input wire logic press_b_i, // Operator holds B.
    output logic hand_a_o = 1'b1, // Contact A.
    output logic hand_b_o = 1'b1 // Contact B.
);
    // Contacts lag the operator by an edge, so no change meets the sampling edge.
    always @(posedge clk_i)
    begin
        hand_a_o <= press_a_i;
        hand_b_o <= press_b_i;
    end
endmodule // dhi_hand_ctl

//--- verification/thc_monitor_tb.sv
`timescale 1ns/1ps
`include "thc_consts.svh"
module dhi_monitor_tb;
    // A short tick lets the window run out well inside the cycle budget.
    localparam int unsigned TICK_CYC = 4;
    localparam int WIN_CYC = `DHI_WINDOW_MS * TICK_CYC;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pa = 1'b1;
    logic pb = 1'b1;
    logic ha;
    logic hb;
    logic permit;
    logic wrel;
    logic [31:0] rng = 32'h0000002B;
    logic sel;
    int err_count = 0;
    int compares = 0;
    initial forever #2.5 clk = ~clk;
    dhi_hand_ctl u_dhi_hand_ctl (.clk_i(clk), .press_a_i(pa), .press_b_i(pb), .hand_a_o(ha), .hand_b_o(hb));
    dhi_monitor #(.TICK_CYC(TICK_CYC)) u_dhi_monitor (.CLOCK_I(clk), .RST_N_I(rst_n), .HAND_A_I(ha),
        .HAND_B_I(hb), .RUN_PERMIT_O(permit), .WAIT_RELEASE_O(wrel));
    // --------------------------------
    // Helpers
    // --------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Permission needs both hands and a fresh start.
    function automatic logic exp_run(input logic a, input logic b, input logic fresh);
        return a & b & fresh;
    endfunction
    task automatic check(input logic seen, input logic exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic hands(input logic a, input logic b);
        @(posedge clk);
        pa <= a;
        pb <= b;
    endtask
    task automatic await(input logic exp);
        int n;
        n = 0;
        while (permit !== exp && n < 12)
        begin
            idle(1);
            n++;
        end
        if (permit !== exp)
        begin
            err_count++;
            complete_run();
        end
    endtask
    // --------------------------------
    // Sequence
    // --------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        idle(20);
        check(permit, 1'b0);
        check(wrel, 1'b1);
        hands(1'b0, 1'b0);
        idle(10);
        check(wrel, 1'b0);
        $display("reset lockout test done");
        for (int i = 0; i < 16; i++)
        begin
            rng = xs(rng);
            sel = rng[0];
            hands(sel, ~sel);
            idle(rng[13:8] % 40);
            hands(1'b1, 1'b1);
            await(1'b1);
            check(permit, exp_run(ha, hb, 1'b1));
            hands(~sel, sel);
            await(1'b0);
            check(wrel, 1'b1);
            hands(1'b1, 1'b1);
            idle(12);
            check(permit, exp_run(ha, hb, 1'b0));
            hands(1'b0, 1'b0);
            idle(10);
            check(wrel, 1'b0);
        end
        $display("two hand cycle test done");
        // Second hand late: the window runs out and locks until both are released.
        hands(1'b1, 1'b0);
        idle(WIN_CYC + 40);
        hands(1'b1, 1'b1);
        idle(12);
        check(permit, exp_run(ha, hb, 1'b0));
        hands(1'b0, 1'b1);
        idle(12);
        check(wrel, 1'b1);
        hands(1'b0, 1'b0);
        idle(10);
        check(wrel, 1'b0);
        // Second hand just inside the window still grants the permit.
        hands(1'b0, 1'b1);
        idle(WIN_CYC - 40);
        hands(1'b1, 1'b1);
        await(1'b1);
        check(permit, exp_run(ha, hb, 1'b1));
        $display("window test done");
        // Reset in mid-run with both hands held must not leave the permit on.
        @(posedge clk);
        rst_n <= 1'b0;
        idle(8);
        check(permit, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        idle(20);
        check(wrel, 1'b1);
        check(permit, 1'b0);
        hands(1'b0, 1'b0);
        idle(10);
        check(wrel, 1'b0);
        hands(1'b1, 1'b1);
        await(1'b1);
        check(permit, exp_run(ha, hb, 1'b1));
        $display("mid-run reset test done");
        complete_run();
    end
endmodule // dhi_monitor_tb
